// [src/caf_pkg.sv]
// Package for the acceptance filter: register map, frame carrier and state codes.
package caf_pkg;
    localparam int RegAddrWidth = 4;
    localparam logic [3:0] CodeByte0Offset = 4'h0;
    localparam logic [3:0] CodeByte1Offset = 4'h1;
    localparam logic [3:0] CodeByte2Offset = 4'h2;
    localparam logic [3:0] CodeByte3Offset = 4'h3;
    localparam logic [3:0] MaskByte0Offset = 4'h4;
    localparam logic [3:0] MaskByte1Offset = 4'h5;
    localparam logic [3:0] MaskByte2Offset = 4'h6;
    localparam logic [3:0] MaskByte3Offset = 4'h7;
    localparam logic [3:0] StatusOffset = 4'h8;
    localparam logic [3:0] AcceptCountOffset = 4'h9;
    localparam logic [3:0] RejectCountOffset = 4'ha;
    localparam logic [7:0] CodeResetValue = 8'h00;
    localparam logic [7:0] MaskResetValue = 8'hff;
    localparam logic [31:0] StdIgnoreBits = 32'h000f_0000;
    localparam logic [31:0] ExtIgnoreBits = 32'h0000_0003;

    typedef struct packed {
        logic extended;
        logic [28:0] ident;
        logic remote;
        logic [7:0] data0;
        logic [7:0] data1;
    } caf_frame_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_DONE = 1'b1
    } caf_state_type;
endpackage : caf_pkg

// [src/can_acceptance_filter.sv]
// Acceptance filter that passes or drops each received frame by code and mask bytes.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/10ps

module can_acceptance_filter (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Register port.
    input wire logic [caf_pkg::RegAddrWidth-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData_reg,
    // Header of a frame from the protocol controller, valid for one cycle.
    input wire logic headerValid,
    input wire caf_pkg::caf_frame_type headerFrame,
    // Frame end from the controller; accepted frames commit to the host buffer one cycle later.
    input wire logic frameEnd,
    // Decision towards the receive buffer.
    output logic acceptValid_reg,
    output logic accept_reg,
    output logic frameCommit_reg
);
    logic [7:0] codeByte_reg [4];
    logic [7:0] maskByte_reg [4];
    logic [31:0] codeWord;
    logic [31:0] maskWord;
    logic [31:0] frameWord;
    logic [31:0] ignoreWord;
    logic matchNow;
    logic decided_reg;
    logic verdict_reg;
    logic [7:0] acceptCount_reg;
    logic [7:0] rejectCount_reg;
    caf_pkg::caf_state_type state_reg;
    caf_pkg::caf_state_type state_next;

    // Code and mask storage; masks come out of reset open so every frame passes.
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_bytes
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    codeByte_reg[i] <= caf_pkg::CodeResetValue;
                    maskByte_reg[i] <= caf_pkg::MaskResetValue;
                end else if (regWrite) begin
                    if (regAddr == caf_pkg::CodeByte0Offset + 4'(i)) begin
                        codeByte_reg[i] <= regWrData;
                    end
                    if (regAddr == caf_pkg::MaskByte0Offset + 4'(i)) begin
                        maskByte_reg[i] <= regWrData;
                    end
                end
            end
            assign codeWord[31-8*i -: 8] = codeByte_reg[i];
            assign maskWord[31-8*i -: 8] = maskByte_reg[i];
        end
    endgenerate

    // Frame bits are laid out most significant first against byte 0 bit 7.
    always_comb begin
        if (headerFrame.extended) begin
            frameWord = {headerFrame.ident, headerFrame.remote, 2'h0};
            ignoreWord = caf_pkg::ExtIgnoreBits;
        end else begin
            frameWord = {headerFrame.ident[10:0], headerFrame.remote, 4'h0,
                headerFrame.data0, headerFrame.data1};
            ignoreWord = caf_pkg::StdIgnoreBits;
        end
    end

    // Only bits with a zero mask and not ignored can fail the match.
    assign matchNow = ((frameWord ^ codeWord) & ~maskWord & ~ignoreWord) == 32'h0;

    // The verdict is latched from the header and held until the frame ends, so a late
    // register write cannot flip a frame already judged.
    always_comb begin
        case (state_reg)
            caf_pkg::ST_IDLE: state_next = headerValid ? caf_pkg::ST_DONE : caf_pkg::ST_IDLE;
            caf_pkg::ST_DONE: state_next = frameEnd ? caf_pkg::ST_IDLE : caf_pkg::ST_DONE;
            default: state_next = caf_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= caf_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            verdict_reg <= 1'b0;
            decided_reg <= 1'b0;
        end else if (state_reg == caf_pkg::ST_IDLE && headerValid) begin
            verdict_reg <= matchNow;
            decided_reg <= 1'b1;
        end else if (state_reg == caf_pkg::ST_DONE && frameEnd) begin
            decided_reg <= 1'b0;
        end
    end

    // Decision pulse one cycle after the header.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            acceptValid_reg <= 1'b0;
            accept_reg <= 1'b0;
        end else begin
            acceptValid_reg <= state_reg == caf_pkg::ST_IDLE && headerValid;
            if (state_reg == caf_pkg::ST_IDLE && headerValid) begin
                accept_reg <= matchNow;
            end
        end
    end

    // Only accepted frames are committed to the host-visible buffer.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            frameCommit_reg <= 1'b0;
        end else begin
            frameCommit_reg <= state_reg == caf_pkg::ST_DONE && frameEnd && verdict_reg;
        end
    end

    // Saturating counters show software how the filter is behaving.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            acceptCount_reg <= 8'h00;
            rejectCount_reg <= 8'h00;
        end else if (state_reg == caf_pkg::ST_IDLE && headerValid) begin
            if (matchNow && acceptCount_reg != 8'hff) begin
                acceptCount_reg <= acceptCount_reg + 8'h01;
            end
            if (!matchNow && rejectCount_reg != 8'hff) begin
                rejectCount_reg <= rejectCount_reg + 8'h01;
            end
        end
    end

    // Read data stand in the cycle after the strobe only; unmapped reads give zero.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regRdData_reg <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                caf_pkg::CodeByte0Offset: regRdData_reg <= codeByte_reg[0];
                caf_pkg::CodeByte1Offset: regRdData_reg <= codeByte_reg[1];
                caf_pkg::CodeByte2Offset: regRdData_reg <= codeByte_reg[2];
                caf_pkg::CodeByte3Offset: regRdData_reg <= codeByte_reg[3];
                caf_pkg::MaskByte0Offset: regRdData_reg <= maskByte_reg[0];
                caf_pkg::MaskByte1Offset: regRdData_reg <= maskByte_reg[1];
                caf_pkg::MaskByte2Offset: regRdData_reg <= maskByte_reg[2];
                caf_pkg::MaskByte3Offset: regRdData_reg <= maskByte_reg[3];
                caf_pkg::StatusOffset: regRdData_reg <= {6'h00, verdict_reg, decided_reg};
                caf_pkg::AcceptCountOffset: regRdData_reg <= acceptCount_reg;
                caf_pkg::RejectCountOffset: regRdData_reg <= rejectCount_reg;
                default: regRdData_reg <= 8'h00;
            endcase
        end else begin
            regRdData_reg <= 8'h00;
        end
    end
endmodule : can_acceptance_filter

// [verification/caf_chk.sv]
// Port checker for the acceptance filter verdict and commit timing.
`timescale 1ns/10ps
module caf_chk (
    // Clock, reset and frame handshake.
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic headerValid,
    input wire logic frameEnd,
    input wire logic acceptValid_reg,
    input wire logic accept_reg,
    input wire logic frameCommit_reg
);
    logic pend;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // A header taken while a frame is open is ignored, so track the open frame.
    always_ff @(posedge sys_clk) pend <= !reset && (pend ? !frameEnd : headerValid);
    sequence s_take; headerValid && !pend; endsequence
    sequence s_close; frameEnd && pend; endsequence
    property p_take; s_take |=> acceptValid_reg; endproperty
    a_take: assert property (p_take) else $error("no verdict after header");
    property p_skip; headerValid && pend |=> !acceptValid_reg; endproperty
    a_skip: assert property (p_skip) else $error("header taken mid frame");
    property p_pulse; acceptValid_reg |=> !acceptValid_reg; endproperty
    a_pulse: assert property (p_pulse) else $error("verdict strobe too long");
    property p_cause; acceptValid_reg |-> $past(headerValid); endproperty
    a_cause: assert property (p_cause) else $error("verdict without header");
    property p_hold; !$past(reset) && !acceptValid_reg |-> $stable(accept_reg); endproperty
    a_hold: assert property (p_hold) else $error("verdict moved between headers");
    property p_commit; s_close |=> frameCommit_reg == accept_reg; endproperty
    a_commit: assert property (p_commit) else $error("commit differs from verdict");
    property p_origin; frameCommit_reg |-> $past(frameEnd) && accept_reg; endproperty
    a_origin: assert property (p_origin) else $error("commit without cause");
    property p_once; frameCommit_reg |=> !frameCommit_reg; endproperty
    a_once: assert property (p_once) else $error("commit strobe too long");
endmodule : caf_chk
bind can_acceptance_filter caf_chk i_chk (
    .sys_clk(sys_clk),
    .reset(reset),
    .headerValid(headerValid),
    .frameEnd(frameEnd),
    .acceptValid_reg(acceptValid_reg),
    .accept_reg(accept_reg),
    .frameCommit_reg(frameCommit_reg)
);

// [verification/caf_rx_model.sv]
// Model of the protocol controller receive path delivering frames.
`timescale 1ns/10ps
module caf_rx_model (
    // Frame side towards the filter.
    input wire logic sys_clk,
    output logic headerValid,
    output caf_pkg::caf_frame_type headerFrame,
    output logic frameEnd
);
    initial {headerValid, frameEnd, headerFrame} = '0;
    // Header fields are inverted once the strobe drops so stale values never match.
    task automatic send(input caf_pkg::caf_frame_type f);
        @(posedge sys_clk) {headerValid, headerFrame} <= {1'b1, f};
        @(posedge sys_clk) {headerValid, headerFrame, frameEnd} <= {1'b0, ~f, 1'b1};
        @(posedge sys_clk) frameEnd <= 1'b0;
    endtask : send
    // A second header while the first frame is still open must be ignored.
    task automatic send_twice(input caf_pkg::caf_frame_type f, input caf_pkg::caf_frame_type g);
        @(posedge sys_clk) {headerValid, headerFrame} <= {1'b1, f};
        @(posedge sys_clk) {headerValid, headerFrame} <= {1'b1, g};
        @(posedge sys_clk) {headerValid, headerFrame, frameEnd} <= {1'b0, ~g, 1'b1};
        @(posedge sys_clk) frameEnd <= 1'b0;
    endtask : send_twice
endmodule : caf_rx_model

// [verification/can_acceptance_filter_test.sv]
// Self-checking bench for the acceptance filter.
`timescale 1ns/10ps
module can_acceptance_filter_test;
    logic sys_clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, regRdData_reg;
    logic headerValid, frameEnd, acceptValid_reg, accept_reg, frameCommit_reg;
    caf_pkg::caf_frame_type headerFrame;
    int errTotal = 0, nCompared = 0;
    always #4 sys_clk = ~sys_clk;
    can_acceptance_filter i_dut (
        .sys_clk(sys_clk),
        .reset(reset),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdData_reg(regRdData_reg),
        .headerValid(headerValid),
        .headerFrame(headerFrame),
        .frameEnd(frameEnd),
        .acceptValid_reg(acceptValid_reg),
        .accept_reg(accept_reg),
        .frameCommit_reg(frameCommit_reg)
    );
    caf_rx_model i_rx (
        .sys_clk(sys_clk),
        .headerValid(headerValid),
        .headerFrame(headerFrame),
        .frameEnd(frameEnd)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nCompared++;
        if (got !== exp) $display("Error at %0t: got %h exp %h", $time, got, exp);
        errTotal += int'(got !== exp);
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk) {regWrite, regRead, regAddr, regWrData} <= {w, !w, a, d};
        @(posedge sys_clk) {regWrite, regRead} <= 2'b00;
        #1 if (!w) chk(regRdData_reg, d);
    endtask : bus
    task automatic frm(input caf_pkg::caf_frame_type f, input logic exp);
        i_rx.send(f);
        #1 chk(frameCommit_reg, exp);
        chk(accept_reg, exp);
    endtask : frm
    task automatic t_std();
        for (int i = 0; i < 8; i++) bus(1'b0, 4'(i), i < 4 ? 8'h00 : 8'hff);
        bus(1'b0, 4'hf, 8'h00);
        for (int i = 0; i < 8; i++) bus(1'b1, 4'(i), 8'(64'h421f5a0038e000ff >> (56 - 8 * i)));
        frm('{1'b0, 29'h1000_03d5, 1'b1, 8'h5a, 8'h00}, 1'b1);
        frm('{1'b0, 29'h0000_03d5, 1'b0, 8'h5a, 8'h00}, 1'b0);
        frm('{1'b0, 29'h0000_03d5, 1'b1, 8'h5b, 8'h00}, 1'b0);
        frm('{1'b0, 29'h0000_07d5, 1'b1, 8'h5a, 8'h00}, 1'b0);
        frm('{1'b0, 29'h0000_0210, 1'b1, 8'h5a, 8'hff}, 1'b1);
        bus(1'b0, caf_pkg::StatusOffset, 8'h02);
        bus(1'b0, caf_pkg::AcceptCountOffset, 8'h02);
        bus(1'b0, caf_pkg::RejectCountOffset, 8'h03);
        $display("t_std done");
    endtask : t_std
    task automatic t_ext();
        for (int i = 0; i < 8; i++) bus(1'b1, 4'(i), 8'(64'hb4b0c03300010f04 >> (56 - 8 * i)));
        frm('{1'b1, 29'h1696_1826, 1'b1, 8'h00, 8'h00}, 1'b1);
        frm('{1'b1, 29'h0696_1806, 1'b0, 8'h00, 8'h00}, 1'b0);
        frm('{1'b1, 29'h1696_1807, 1'b0, 8'h00, 8'h00}, 1'b0);
        $display("t_ext done");
    endtask : t_ext
    task automatic t_busy();
        i_rx.send_twice('{1'b1, 29'h1696_1826, 1'b1, 8'h00, 8'h00},
            '{1'b1, 29'h0696_1806, 1'b0, 8'h00, 8'h00});
        #1 chk(frameCommit_reg, 1'b1);
        chk(accept_reg, 1'b1);
        bus(1'b0, caf_pkg::AcceptCountOffset, 8'h04);
        bus(1'b0, caf_pkg::RejectCountOffset, 8'h05);
        $display("t_busy done");
    endtask : t_busy
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        t_std();
        t_ext();
        t_busy();
        report_and_stop();
    end
endmodule : can_acceptance_filter_test
